/* File: verilog/pmta_pkg.sv */
/*
 * Shared constants and types of the program memory table access unit:
 * register map of the Avalon-MM slave, field positions, reset values,
 * command and state encodings, and the carrier structs.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pmta_pkg;

   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int PTR_W = 16;
   localparam int LATCH_W = 16;
   localparam int BYTE_W = 8;
   localparam int AV_ADDR_W = 4;
   localparam int AV_DATA_W = 32;
   localparam int NUM_CORE_SRC = 3; // pin, timer-zero clock pin, timer-zero overflow

   // ------------------------------------------------------------------
   // register map (byte addresses) and fields
   // ------------------------------------------------------------------
   localparam logic [AV_ADDR_W-1:0] REG_PTR = 4'h0;
   localparam logic [AV_ADDR_W-1:0] REG_LATCH = 4'h4;
   localparam logic [AV_ADDR_W-1:0] REG_CTRL = 4'h8;
   localparam logic [AV_ADDR_W-1:0] REG_STAT = 4'hC;
   localparam int CTRL_EXT_BIT = 0;
   localparam int STAT_LONG_BIT = 0;
   localparam int STAT_ABORT_BIT = 1;
   localparam int STAT_VPP_BIT = 2;
   localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
   localparam logic [LATCH_W-1:0] LATCH_RST = 16'h0000;
   localparam logic CTRL_EXT_RST = 1'b0;
   localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;

   // ------------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      PMTA_OP_NONE = 3'b000,
      PMTA_OP_LATCH_WR = 3'b001, // latch_byte_write_instr
      PMTA_OP_WORD_WR = 3'b010,  // program_word_write_instr
      PMTA_OP_LATCH_RD = 3'b011, // latch_byte_read_instr
      PMTA_OP_WORD_RD = 3'b100   // program_word_read_instr
   } pmta_op_e;

   typedef enum logic [2:0] {
      PMTA_ST_IDLE = 3'b000,
      PMTA_ST_RD2 = 3'b001,
      PMTA_ST_XW2 = 3'b010,
      PMTA_ST_IW2 = 3'b011,
      PMTA_ST_LONG = 3'b100
   } pmta_st_e;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      pmta_op_e op;
      logic hi_sel;
      logic incr;
      logic [BYTE_W-1:0] data;
   } pmta_cmd_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic prog;
      logic ext;
      logic [PTR_W-1:0] addr;
      logic [LATCH_W-1:0] wdata;
   } pmta_mem_s;

   typedef struct packed {
      logic [NUM_CORE_SRC-1:0] clr;
      logic vector;
      logic periph_ack;
   } pmta_irq_s;

   typedef struct packed {
      pmta_st_e st;
      logic [PTR_W-1:0] ptr;
      logic [LATCH_W-1:0] latch;
      logic ext_mode;
      logic abort;
      logic incr;
      logic vpp_meta;
      logic vpp_ok;
      logic ack;
      logic [AV_DATA_W-1:0] rdata;
      logic [BYTE_W-1:0] rd_byte;
      logic rd_valid;
      pmta_irq_s irq;
   } pmta_state_s;

endpackage

/* File: verilog/pmta_irq_pick.sv */
/*
 * Priority picker over interrupt sources: flags a source that is both
 * enabled and flagged, and names the highest one (index 0 first).
 * Assumes enables and flags come from logic on the same clock.
 */
`timescale 1ns/1ps

module pmta_irq_pick #(
   parameter int N = 3
) (
   input wire logic [N-1:0] en_i,
   input wire logic [N-1:0] flag_i,
   output logic any_o,
   output logic [N-1:0] top_o
);

   // ------------------------------------------------------------------
   // one-hot of the lowest pending index
   // ------------------------------------------------------------------
   always_comb begin
      logic [N-1:0] pend;
      pend = en_i & flag_i;
      top_o = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend[i]) begin
            top_o = '0;
            top_o[i] = 1'b1;
         end
      end
      any_o = |pend;
   end

endmodule

/* File: verilog/pmta_table_access.sv */
/*
 * Table access unit: moves bytes between data space and 16-bit program
 * words through a holding latch and a word pointer, drives internal or
 * external program memory, and runs the interrupt-ended long write.
 * Assumes the core issues one command per cycle only while stall_o is
 * low, and that program memory read data is valid in the cycle rd is high.
 */
`timescale 1ns/1ps

// Functional notes
// - A program word moves to or from data space in two byte operations.
// - Latch-load and word-write copy a data byte into upper or lower latch byte.
// - Word-write stores the whole 16-bit latch at the pointer address.
// - Increment operand one advances pointer after a write (not an aborted one) and before a word-read refill; zero leaves it.
// - Internal word-write starts a long write that stalls the core.
// - Only reset or an enabled and flagged source ends a long write.
// - Global disable decides only vectoring when a long write ends.
// - Pin or timer-zero source ending long write has its flag cleared.
// - Peripheral source ending long write keeps its flag set.
// - Pending enabled interrupt aborts internal word-write; top core flag cleared.
// - Without programming voltage internal write takes two cycles, memory unchanged.
// - External word-write takes exactly two cycles, writing in the second.
// - External write completes despite interrupts; flag cleared or peripheral acknowledged.
// - External memory is used only in extended or microprocessor mode.
// - Word-read refills the latch, so the first read after setup is stale.
// - Word-read returns latch byte first, then refills from updated pointer.
module pmta_table_access
   import pmta_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // avalon-mm slave
   input wire logic [AV_ADDR_W-1:0] av_address_i,
   input wire logic av_read_i,
   input wire logic av_write_i,
   input wire logic [AV_DATA_W-1:0] av_writedata_i,
   input wire logic [3:0] av_byteenable_i,
   output logic [AV_DATA_W-1:0] av_readdata_o,
   output logic av_waitrequest_o,
   // core command side
   input wire logic cmd_valid_i,
   input wire pmta_cmd_s cmd_i,
   output logic stall_o,
   output logic [BYTE_W-1:0] rd_data_o,
   output logic rd_valid_o,
   // interrupt state from the core, index 0 highest priority
   input wire logic [NUM_CORE_SRC-1:0] core_irq_en_i,
   input wire logic [NUM_CORE_SRC-1:0] core_irq_flag_i,
   input wire logic periph_irq_en_i,
   input wire logic periph_irq_flag_i,
   input wire logic global_irq_disable_i,
   output pmta_irq_s irq_resp_o,
   // program voltage good, from reset_program_voltage_pin comparator
   input wire logic prog_voltage_ok_i,
   // program memory port
   output pmta_mem_s pmem_o,
   input wire logic [LATCH_W-1:0] pmem_rdata_i
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   pmta_state_s s_ff;
   pmta_state_s nxt_s;
   logic core_any;
   logic [NUM_CORE_SRC-1:0] core_top;
   logic periph_hit;
   logic pend_any;
   logic req;
   logic blk;
   logic take;
   logic idle;
   logic cmd_go;

   // merge a 16-bit field with the low two byte lanes of a bus write
   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [AV_DATA_W-1:0] wd,
                                              input logic [3:0] be);
      lane_merge = old;
      if (be[0]) begin
         lane_merge[7:0] = wd[7:0];
      end
      if (be[1]) begin
         lane_merge[15:8] = wd[15:8];
      end
   endfunction

   // place a data byte into the chosen latch half
   function automatic logic [15:0] latch_put(input logic [15:0] old,
                                             input logic hi,
                                             input logic [7:0] b);
      latch_put = hi ? {b, old[7:0]} : {old[15:8], b};
   endfunction

   // ------------------------------------------------------------------
   // interrupt priority
   // ------------------------------------------------------------------
   pmta_irq_pick #(
      .N(NUM_CORE_SRC)
   ) u_pick (
      .en_i(core_irq_en_i),
      .flag_i(core_irq_flag_i),
      .any_o(core_any),
      .top_o(core_top)
   );

   // a source counts only with enable and flag both set
   assign periph_hit = periph_irq_en_i & periph_irq_flag_i;
   assign pend_any = core_any | periph_hit;

   // ------------------------------------------------------------------
   // handshake terms
   // ------------------------------------------------------------------
   assign idle = (s_ff.st == PMTA_ST_IDLE);
   assign cmd_go = cmd_valid_i & idle;
   assign req = av_read_i | av_write_i;
   // bus writes wait while a command owns pointer and latch
   assign blk = av_write_i & (!idle | cmd_valid_i);
   assign take = req & s_ff.ack & !blk;
   assign av_waitrequest_o = req & !take;
   assign stall_o = !idle;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.rd_valid = 1'b0;
      nxt_s.irq = '0;
      nxt_s.vpp_meta = prog_voltage_ok_i;
      nxt_s.vpp_ok = s_ff.vpp_meta;
      nxt_s.ack = req & !s_ff.ack;

      // register read data captured on the first request cycle
      if (req & !s_ff.ack) begin
         nxt_s.rdata = '0;
         unique case (av_address_i)
            REG_PTR: nxt_s.rdata[PTR_W-1:0] = s_ff.ptr;
            REG_LATCH: nxt_s.rdata[LATCH_W-1:0] = s_ff.latch;
            REG_CTRL: nxt_s.rdata[CTRL_EXT_BIT] = s_ff.ext_mode;
            REG_STAT: begin
               nxt_s.rdata[STAT_LONG_BIT] = (s_ff.st == PMTA_ST_LONG);
               nxt_s.rdata[STAT_ABORT_BIT] = s_ff.abort;
               nxt_s.rdata[STAT_VPP_BIT] = s_ff.vpp_ok;
            end
            default: nxt_s.rdata = '0;
         endcase
      end

      // register writes
      if (take & av_write_i) begin
         unique case (av_address_i)
            REG_PTR: nxt_s.ptr = lane_merge(s_ff.ptr, av_writedata_i, av_byteenable_i);
            REG_LATCH: nxt_s.latch = lane_merge(s_ff.latch, av_writedata_i, av_byteenable_i);
            REG_CTRL: begin
               if (av_byteenable_i[0]) begin
                  nxt_s.ext_mode = av_writedata_i[CTRL_EXT_BIT];
               end
            end
            REG_STAT: begin
               if (av_byteenable_i[0] & av_writedata_i[STAT_ABORT_BIT]) begin
                  nxt_s.abort = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // command sequencer
      unique case (s_ff.st)
         PMTA_ST_IDLE: begin
            if (cmd_go) begin
               unique case (cmd_i.op)
                  PMTA_OP_NONE: ;
                  PMTA_OP_LATCH_WR: begin
                     nxt_s.latch = latch_put(s_ff.latch, cmd_i.hi_sel, cmd_i.data);
                  end
                  PMTA_OP_LATCH_RD: begin
                     nxt_s.rd_byte = cmd_i.hi_sel ? s_ff.latch[15:8] : s_ff.latch[7:0];
                     nxt_s.rd_valid = 1'b1;
                  end
                  PMTA_OP_WORD_WR: begin
                     nxt_s.latch = latch_put(s_ff.latch, cmd_i.hi_sel, cmd_i.data);
                     nxt_s.incr = cmd_i.incr;
                     if (s_ff.ext_mode) begin
                        nxt_s.st = PMTA_ST_XW2;
                     end else if (pend_any) begin
                        nxt_s.abort = 1'b1;
                        nxt_s.irq.clr = core_top;
                     end else if (!s_ff.vpp_ok) begin
                        nxt_s.st = PMTA_ST_IW2;
                     end else begin
                        nxt_s.st = PMTA_ST_LONG;
                     end
                  end
                  PMTA_OP_WORD_RD: begin
                     // stale latch byte first, refill next cycle
                     nxt_s.rd_byte = cmd_i.hi_sel ? s_ff.latch[15:8] : s_ff.latch[7:0];
                     nxt_s.rd_valid = 1'b1;
                     if (cmd_i.incr) begin
                        nxt_s.ptr = s_ff.ptr + PTR_ONE;
                     end
                     nxt_s.st = PMTA_ST_RD2;
                  end
                  default: ;
               endcase
            end
         end
         PMTA_ST_RD2: begin
            nxt_s.latch = pmem_rdata_i;
            nxt_s.st = PMTA_ST_IDLE;
         end
         PMTA_ST_IW2: begin
            if (s_ff.incr) begin
               nxt_s.ptr = s_ff.ptr + PTR_ONE;
            end
            nxt_s.st = PMTA_ST_IDLE;
         end
         PMTA_ST_XW2: begin
            if (s_ff.incr) begin
               nxt_s.ptr = s_ff.ptr + PTR_ONE;
            end
            if (core_any) begin
               nxt_s.irq.clr = core_top;
            end else if (periph_hit) begin
               nxt_s.irq.periph_ack = 1'b1;
            end
            nxt_s.st = PMTA_ST_IDLE;
         end
         PMTA_ST_LONG: begin
            if (pend_any) begin
               if (s_ff.incr) begin
                  nxt_s.ptr = s_ff.ptr + PTR_ONE;
               end
               // top core source cleared, a peripheral flag is left alone
               nxt_s.irq.clr = core_any ? core_top : '0;
               nxt_s.irq.vector = !global_irq_disable_i;
               nxt_s.st = PMTA_ST_IDLE;
            end
         end
         default: nxt_s.st = PMTA_ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------------
   // state register, reset also ends a long write
   // ------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         s_ff <= '{st: PMTA_ST_IDLE, ptr: PTR_RST, latch: LATCH_RST,
                   ext_mode: CTRL_EXT_RST, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   always_comb begin
      pmem_o.addr = s_ff.ptr;
      pmem_o.wdata = s_ff.latch;
      pmem_o.ext = s_ff.ext_mode;
      pmem_o.rd = (s_ff.st == PMTA_ST_RD2);
      pmem_o.wr = (s_ff.st == PMTA_ST_XW2);
      pmem_o.prog = (s_ff.st == PMTA_ST_LONG) & s_ff.vpp_ok;
   end

   assign av_readdata_o = s_ff.rdata;
   assign rd_data_o = s_ff.rd_byte;
   assign rd_valid_o = s_ff.rd_valid;
   assign irq_resp_o = s_ff.irq;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_rd_seq;
      cmd_go & (cmd_i.op == PMTA_OP_WORD_RD) |=> rd_valid_o & pmem_o.rd ##1 !stall_o & !rd_valid_o;
   endproperty
   a_rd_seq: assert property (p_rd_seq) else $error("word read not two cycles");

   property p_latch_rd;
      cmd_go & (cmd_i.op == PMTA_OP_LATCH_RD) & cmd_i.hi_sel
         |=> rd_valid_o & (rd_data_o == $past(s_ff.latch[15:8])) & !pmem_o.rd;
   endproperty
   a_latch_rd: assert property (p_latch_rd) else $error("latch upper read wrong");

   property p_latch_wr;
      cmd_go & (cmd_i.op == PMTA_OP_LATCH_WR) & !cmd_i.hi_sel
         |=> (s_ff.latch[7:0] == $past(cmd_i.data)) & (s_ff.latch[15:8] == $past(s_ff.latch[15:8]));
   endproperty
   a_latch_wr: assert property (p_latch_wr) else $error("latch lower load wrong");

   property p_ptr_step;
      pmem_o.wr & s_ff.incr |=> s_ff.ptr == $past(s_ff.ptr) + PTR_ONE;
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced");

   property p_ptr_hold;
      (s_ff.st == PMTA_ST_IW2) & !s_ff.incr |=> $stable(s_ff.ptr);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved without increment");

   property p_ext_two;
      cmd_go & (cmd_i.op == PMTA_OP_WORD_WR) & s_ff.ext_mode
         |=> pmem_o.wr & pmem_o.ext & stall_o ##1 !stall_o & !pmem_o.wr;
   endproperty
   a_ext_two: assert property (p_ext_two) else $error("external write not two cycles");

   property p_long_hold;
      (s_ff.st == PMTA_ST_LONG) & !pend_any |=> (s_ff.st == PMTA_ST_LONG) & stall_o;
   endproperty
   a_long_hold: assert property (p_long_hold) else $error("long write ended without cause");

   property p_abort;
      cmd_go & (cmd_i.op == PMTA_OP_WORD_WR) & !s_ff.ext_mode & pend_any
         |=> !stall_o & s_ff.abort & (irq_resp_o.clr == $past(core_top));
   endproperty
   a_abort: assert property (p_abort) else $error("pending interrupt did not abort write");

   property p_periph_end;
      (s_ff.st == PMTA_ST_LONG) & periph_hit & !core_any
         |=> (irq_resp_o.clr == '0) & (irq_resp_o.vector == !$past(global_irq_disable_i)) & !stall_o;
   endproperty
   a_periph_end: assert property (p_periph_end) else $error("peripheral end of long write wrong");

   property p_no_vpp;
      cmd_go & (cmd_i.op == PMTA_OP_WORD_WR) & !s_ff.ext_mode & !pend_any & !s_ff.vpp_ok
         |=> !pmem_o.prog & !pmem_o.wr & stall_o ##1 !stall_o;
   endproperty
   a_no_vpp: assert property (p_no_vpp) else $error("write without voltage not two cycles");

endmodule

/* File: tb/pmta_pmem_model.sv */
/*
 * Program memory model on the far side of the table access unit.
 * Assumes the unit's memory port and one clock; 256 words, address aliased.
 */
`timescale 1ns/1ps

module pmta_pmem_model
   import pmta_pkg::*;
(
   input wire logic clock_i,
   input wire pmta_mem_s mem_i,
   output logic [LATCH_W-1:0] rdata_o
);
   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   logic [LATCH_W-1:0] word_q [0:255];
   logic [LATCH_W-1:0] last_q = 16'h0000;

   // preload: address in high byte, its inverse in low byte
   initial begin
      for (int i = 0; i < 256; i++) begin
         word_q[i] = {i[7:0], ~i[7:0]};
      end
   end

   // released read bus shows inverse of the last word
   assign rdata_o = mem_i.rd ? word_q[mem_i.addr[7:0]] : ~last_q;

   // external write or program strobe stores the latch word
   always @(posedge clock_i) begin
      if (mem_i.rd) begin
         last_q <= rdata_o;
      end
      if (mem_i.wr || mem_i.prog) begin
         word_q[mem_i.addr[7:0]] <= mem_i.wdata;
      end
   end
endmodule

/* File: tb/pmta_table_access_test.sv */
/*
 * Self-checking bench of the table access unit.
 * Assumes the design package, the unit and the memory model.
 */
`timescale 1ns/1ps

module program_memory_table_access_test
   import pmta_pkg::*;
;
   // ------------------------------------------------------------------
   // stimulus and observation
   // ------------------------------------------------------------------
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [AV_ADDR_W-1:0] av_address = 4'h0;
   logic av_read = 1'b0;
   logic av_write = 1'b0;
   logic [AV_DATA_W-1:0] av_wdata = 32'h0;
   logic [3:0] av_be = 4'h3;
   logic [AV_DATA_W-1:0] av_rdata;
   logic av_wait;
   logic cmd_valid = 1'b0;
   pmta_cmd_s cmd = '0;
   logic stall;
   logic [BYTE_W-1:0] rd_data;
   logic rd_valid;
   logic [NUM_CORE_SRC-1:0] core_en = 3'h0;
   logic [NUM_CORE_SRC-1:0] core_flag = 3'h0;
   logic per_en = 1'b0;
   logic per_flag = 1'b0;
   logic gid = 1'b0;
   logic vpp = 1'b0;
   pmta_irq_s irq_resp;
   pmta_irq_s acc = '0;
   logic acc_clr = 1'b0;
   pmta_mem_s pmem;
   logic [LATCH_W-1:0] pmem_rdata;
   logic [31:0] r;
   int n;
   int miscompares = 0;
   int checks = 0;

   // clock and pulse collector
   always #10 clock_i = ~clock_i;
   always @(posedge clock_i) acc <= acc_clr ? '0 : (acc | irq_resp);

   pmta_table_access uut (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .av_address_i(av_address),
      .av_read_i(av_read), .av_write_i(av_write), .av_writedata_i(av_wdata),
      .av_byteenable_i(av_be), .av_readdata_o(av_rdata), .av_waitrequest_o(av_wait),
      .cmd_valid_i(cmd_valid), .cmd_i(cmd), .stall_o(stall), .rd_data_o(rd_data),
      .rd_valid_o(rd_valid), .core_irq_en_i(core_en), .core_irq_flag_i(core_flag),
      .periph_irq_en_i(per_en), .periph_irq_flag_i(per_flag),
      .global_irq_disable_i(gid), .irq_resp_o(irq_resp),
      .prog_voltage_ok_i(vpp), .pmem_o(pmem), .pmem_rdata_i(pmem_rdata)
   );

   pmta_pmem_model mem (.clock_i(clock_i), .mem_i(pmem), .rdata_o(pmem_rdata));

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task print_verdict;
      if (miscompares == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task hang;
      miscompares++;
      print_verdict;
   endtask

   function automatic logic [15:0] pat(input logic [15:0] a);
      return {a[7:0], ~a[7:0]};
   endfunction

   // one bus cycle held until waitrequest is seen low
   task av(input logic w, input logic [3:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clock_i);
      av_address <= a;
      av_write <= w;
      av_read <= !w;
      av_wdata <= wd;
      @(posedge clock_i);
      while (av_wait !== 1'b0) begin
         k++;
         if (k > 50) hang;
         @(posedge clock_i);
      end
      r = av_rdata;
      av_read <= 1'b0;
      av_write <= 1'b0;
   endtask

   // one command pulse; returns in the cycle after the take
   task issue(input pmta_op_e op, input logic hi, input logic inc, input logic [7:0] d);
      @(posedge clock_i);
      cmd_valid <= 1'b1;
      acc_clr <= 1'b1;
      cmd <= '{op, hi, inc, d};
      @(posedge clock_i);
      cmd_valid <= 1'b0;
      acc_clr <= 1'b0;
      #1;
   endtask

   // counts stall cycles into n, lets pulses land, returns on an edge
   task settle;
      n = 0;
      while (stall !== 1'b0) begin
         n++;
         if (n > 300) hang;
         @(posedge clock_i);
         #1;
      end
      repeat (2) @(posedge clock_i);
   endtask

   // program word at a into r, pointer left at a
   task fetch(input logic [15:0] a);
      av(1'b1, REG_PTR, {16'h0000, a});
      issue(PMTA_OP_WORD_RD, 1'b0, 1'b0, 8'h00);
      settle;
      av(1'b0, REG_LATCH, 32'h0);
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task s_reset;
      av(1'b0, REG_PTR, 32'h0);
      chk(r[15:0], PTR_RST);
      av(1'b0, REG_LATCH, 32'h0);
      chk(r[15:0], LATCH_RST);
      av(1'b0, REG_CTRL, 32'h0);
      chk(r[15:0], 16'(CTRL_EXT_RST));
      av(1'b0, 4'h1, 32'h0);
      chk(r[15:0], 16'h0000);
   endtask

   task s_latch;
      issue(PMTA_OP_LATCH_WR, 1'b1, 1'b0, 8'hA7);
      issue(PMTA_OP_LATCH_WR, 1'b0, 1'b0, 8'h3C);
      av(1'b0, REG_LATCH, 32'h0);
      chk(r[15:0], 16'hA73C);
      issue(PMTA_OP_LATCH_RD, 1'b1, 1'b0, 8'h00);
      chk(16'({rd_valid, pmem.rd, rd_data}), 16'h02A7);
      issue(PMTA_OP_LATCH_RD, 1'b0, 1'b0, 8'h00);
      chk(16'({rd_valid, pmem.rd, rd_data}), 16'h023C);
      @(posedge clock_i);
      av_be <= 4'h1;
      av(1'b1, REG_LATCH, 32'h0000_5599);
      av_be <= 4'h3;
      av(1'b0, REG_LATCH, 32'h0);
      chk(r[15:0], 16'hA799);
   endtask

   task s_read;
      av(1'b1, REG_PTR, 32'h0000_0020);
      issue(PMTA_OP_WORD_RD, 1'b1, 1'b1, 8'h00);
      chk(16'(rd_data), 16'h00A7);
      chk(16'({stall, pmem.rd}), 16'h0003);
      chk(pmem.addr, 16'h0021);
      settle;
      chk(16'(n), 16'h0001);
      issue(PMTA_OP_LATCH_RD, 1'b1, 1'b0, 8'h00);
      chk(16'(rd_data), 16'h0021);
      issue(PMTA_OP_WORD_RD, 1'b0, 1'b0, 8'h00);
      chk(16'(rd_data), 16'h00DE);
      settle;
      av(1'b0, REG_PTR, 32'h0);
      chk(r[15:0], 16'h0021);
   endtask

   task s_ext;
      core_en <= 3'b011;
      core_flag <= 3'b011;
      av(1'b1, REG_CTRL, 32'h1);
      issue(PMTA_OP_LATCH_WR, 1'b1, 1'b0, 8'h5A);
      issue(PMTA_OP_WORD_WR, 1'b0, 1'b1, 8'hC3);
      chk(16'({pmem.wr, pmem.ext, stall}), 16'h0007);
      chk(pmem.wdata, 16'h5AC3);
      settle;
      chk(16'(n), 16'h0001);
      chk(16'(acc.clr), 16'h0001);
      core_en <= 3'b000;
      core_flag <= 3'b000;
      per_en <= 1'b1;
      per_flag <= 1'b1;
      issue(PMTA_OP_WORD_WR, 1'b0, 1'b0, 8'hC3);
      settle;
      chk(16'(acc), 16'h0001);
      per_en <= 1'b0;
      per_flag <= 1'b0;
      av(1'b0, REG_PTR, 32'h0);
      chk(r[15:0], 16'h0022);
      fetch(16'h0021);
      chk(r[15:0], 16'h5AC3);
   endtask

   task s_long;
      av(1'b1, REG_CTRL, 32'h0);
      vpp <= 1'b1;
      core_flag <= 3'b100;
      per_en <= 1'b1;
      av(1'b1, REG_PTR, 32'h0000_0030);
      av(1'b1, REG_LATCH, 32'h0000_BEEF);
      issue(PMTA_OP_WORD_WR, 1'b0, 1'b1, 8'hEF);
      repeat (6) @(posedge clock_i);
      #1;
      chk(16'({stall, pmem.prog, pmem.ext}), 16'h0006);
      @(posedge clock_i);
      per_flag <= 1'b1;
      settle;
      chk(16'(acc), 16'h0002);
      per_en <= 1'b0;
      per_flag <= 1'b0;
      gid <= 1'b1;
      core_en <= 3'b110;
      core_flag <= 3'b000;
      issue(PMTA_OP_WORD_WR, 1'b0, 1'b1, 8'hEF);
      repeat (4) @(posedge clock_i);
      core_flag <= 3'b110;
      settle;
      chk(16'(acc), 16'h0008);
      core_en <= 3'b000;
      core_flag <= 3'b000;
      gid <= 1'b0;
      av(1'b0, REG_PTR, 32'h0);
      chk(r[15:0], 16'h0032);
      fetch(16'h0030);
      chk(r[15:0], 16'hBEEF);
   endtask

   task s_abort;
      core_en <= 3'b101;
      core_flag <= 3'b101;
      av(1'b1, REG_PTR, 32'h0000_0040);
      issue(PMTA_OP_WORD_WR, 1'b0, 1'b1, 8'h11);
      chk(16'(stall), 16'h0000);
      settle;
      chk(16'(acc.clr), 16'h0001);
      core_en <= 3'b000;
      core_flag <= 3'b000;
      av(1'b0, REG_STAT, 32'h0);
      chk(16'(r[STAT_ABORT_BIT]), 16'h0001);
      av(1'b0, REG_PTR, 32'h0);
      chk(r[15:0], 16'h0040);
      fetch(16'h0040);
      chk(r[15:0], pat(16'h0040));
   endtask

   task s_novpp;
      vpp <= 1'b0;
      av(1'b1, REG_PTR, 32'h0000_0050);
      repeat (4) @(posedge clock_i);
      issue(PMTA_OP_WORD_WR, 1'b0, 1'b1, 8'h77);
      chk(16'(pmem.prog), 16'h0000);
      settle;
      chk(16'(n), 16'h0001);
      issue(PMTA_OP_WORD_WR, 1'b0, 1'b0, 8'h77);
      settle;
      chk(16'(n), 16'h0001);
      av(1'b0, REG_PTR, 32'h0);
      chk(r[15:0], 16'h0051);
      fetch(16'h0050);
      chk(r[15:0], pat(16'h0050));
   endtask

   // reset in mid-run ends a long write at once
   task s_rst_long;
      vpp <= 1'b1;
      repeat (4) @(posedge clock_i);
      issue(PMTA_OP_WORD_WR, 1'b0, 1'b0, 8'h00);
      chk(16'(stall), 16'h0001);
      @(posedge clock_i);
      sys_rst_i <= 1'b1;
      @(posedge clock_i);
      sys_rst_i <= 1'b0;
      #1;
      chk(16'(stall), 16'h0000);
      av(1'b0, REG_LATCH, 32'h0);
      chk(r[15:0], LATCH_RST);
   endtask

   // reset, scenarios, verdict
   initial begin
      repeat (3) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      s_reset;
      s_latch;
      s_read;
      s_ext;
      s_long;
      s_abort;
      s_novpp;
      s_rst_long;
      print_verdict;
   end
endmodule
